// File: qospt_defines.svh
// Purpose: Constants for the QoS priority and tagging block
// Assumes: APB word per register, index = paddr[9:2]
// Notes: Byte address of a register is four times its index
//
// Functional notes
// R1: Egress queue split from ctrl9 bit1 and ctrl0 bit0: 00 one, 01 two, 10 four.
// R2: With four queues, queue 3 is served first, queue 0 last.
// R3: Unsplit port puts every frame in one queue with equal treatment.
// R4: Four queues served strict or weighted fair; 7-bit weights reset 8,4,2,1.
// R5: Two-queue mode maps each 2-bit level to high or low via level map.
// R6: Port-based priority gives every frame the port's configured level 0-3.
// R7: Port level 3 frames go to the high queue when split.
// R8: Tagged frames map 3-bit priority 0-7 to level 0-3 through a table.
// R9: 802.1p classification only when the port's ctrl0 bit5 is set.
// R10: Tag insertion adds ingress default tag, limited by source-port mask.
// R11: Already tagged frames never get a second tag.
// R12: Tag removal strips tags from tagged frames, leaves untagged ones alone.
// R13: Tag is four bytes: two-byte protocol identifier then two-byte control.
// R14: Frame check sequence recomputed whenever a tag is inserted or removed.
// R15: Per-port default tag held in port control 3 and 4 registers.
// R16: Priority ceiling clamps frame priority to default-tag priority.
// R17: DSCP upper six ToS bits select one of 64 points in 128-bit map.
// R18: Code point n uses map bits 2n+1:2n over sixteen byte registers.
`ifndef QOSPT_DEFINES_SVH
`define QOSPT_DEFINES_SVH
`define QOSPT_IDX_MAP_LO 8'h80
`define QOSPT_IDX_MAP_HI 8'h81
`define QOSPT_IDX_LVLMAP 8'h82
`define QOSPT_IDX_DSCP0 8'h90
`define QOSPT_IDX_WT0 8'hA0
`define QOSPT_IDX_STATUS 8'hC0
`define QOSPT_PORT_STRIDE 8'h10
`define QOSPT_OFF_CTRL0 8'h00
`define QOSPT_OFF_CTRL2 8'h02
`define QOSPT_OFF_CTRL3 8'h03
`define QOSPT_OFF_CTRL4 8'h04
`define QOSPT_OFF_CTRL8 8'h08
`define QOSPT_OFF_CTRL9 8'h09
`define QOSPT_RST_MAP_LO 8'h50
`define QOSPT_RST_MAP_HI 8'hFA
`define QOSPT_RST_WT3 7'h08
`define QOSPT_RST_WT2 7'h04
`define QOSPT_RST_WT1 7'h02
`define QOSPT_RST_WT0 7'h01
`define QOSPT_VLAN_PROTOCOL_IDENTIFIER 16'h8100
`define QOSPT_C0_SPLIT 0
`define QOSPT_C0_REMOVE 1
`define QOSPT_C0_INSERT 2
`define QOSPT_C0_PORTLVL 3
`define QOSPT_C0_PRI8021P 5
`define QOSPT_C0_DSCP 6
`define QOSPT_C2_CEILING 7
`define QOSPT_C9_WFQ 0
`define QOSPT_C9_SPLIT 1
`define QOSPT_FIFO_DEPTH 8
`endif

// File: qospt_pkg.sv
// Purpose: Types for the QoS priority and tagging block
// Assumes: Four ports, four queues per port
// Notes: Descriptor carried through the egress FIFO
package qospt_pkg;
  typedef enum logic [1:0] {
    QOSPT_SPLIT_ONE = 2'b00,
    QOSPT_SPLIT_TWO = 2'b01,
    QOSPT_SPLIT_FOUR = 2'b10,
    QOSPT_SPLIT_RSVD = 2'b11
  } qospt_split_t;
  typedef struct packed {
    logic [1:0] egress;
    logic [1:0] queue;
    logic [1:0] level;
    logic ins;
    logic rem;
    logic [15:0] tci;
  } qospt_desc_t;
endpackage : qospt_pkg

// File: qospt_top.sv
// Purpose: Frame classification, queue choice, tag edit and queue scheduling
// Assumes: Ingress MAC presents one descriptor per frame; APB registers
// Notes: FIFO of eight descriptors between classifier and egress
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "qospt_defines.svh"

module qospt_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_reg];
  assign level = count_reg;

  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= AW'(wr_ptr_reg + 1'b1);
      end
      if (pop) begin
        rd_ptr_reg <= AW'(rd_ptr_reg + 1'b1);
      end
      // Flags kept as flops so full and empty are honest every cycle
      if (push && !pop) begin
        count_reg <= (AW+1)'(count_reg + 1'b1);
        in_ready <= count_reg != (AW+1)'(DEPTH - 1);
        out_valid <= 1'b1;
      end else if (pop && !push) begin
        count_reg <= (AW+1)'(count_reg - 1'b1);
        in_ready <= 1'b1;
        out_valid <= count_reg != (AW+1)'(1);
      end else begin
        in_ready <= count_reg != (AW+1)'(DEPTH);
        out_valid <= count_reg != '0;
      end
    end
  end
endmodule : qospt_fifo

module qospt_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [1:0] in_ingress,
  input wire logic [1:0] in_egress,
  input wire logic in_tagged,
  input wire logic [15:0] in_tci,
  input wire logic in_is_ip,
  input wire logic [5:0] in_dscp,
  output logic out_valid,
  input wire logic out_ready,
  output logic [1:0] out_egress,
  output logic [1:0] out_queue,
  output logic [1:0] out_level,
  output logic out_tag_insert,
  output logic out_tag_remove,
  output logic out_crc_recalc,
  output logic [15:0] out_tci,
  output logic [15:0] out_vlan_protocol_identifier,
  input wire logic [15:0] q_pending,
  input wire logic [3:0] tx_take,
  output logic [3:0] grant_valid,
  output logic [7:0] grant_queue
);
  import qospt_pkg::*;

  logic [7:0] ctrl0_reg [4];
  logic [7:0] ctrl2_reg [4];
  logic [7:0] ctrl3_reg [4];
  logic [7:0] ctrl4_reg [4];
  logic [7:0] ctrl8_reg [4];
  logic [7:0] ctrl9_reg [4];
  logic [6:0] wt_reg [16];
  logic [7:0] dscp_reg [16];
  logic [15:0] pri_map_reg;
  logic [7:0] lvlmap_reg;
  logic [15:0] frame_cnt_reg;
  logic [7:0] idx;
  logic setup;
  logic wr_en;
  logic [31:0] rd_data;
  logic rd_hit;
  logic [3:0] fifo_level;
  logic [1:0] two_queue_level_map;

  assign idx = paddr[9:2];
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready && pwrite;
  assign two_queue_level_map = lvlmap_reg[7:6];

  // Register writes; the status word is read-only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < 4; p++) begin
        ctrl0_reg[p] <= 8'h00;
        ctrl2_reg[p] <= 8'h00;
        ctrl3_reg[p] <= 8'h00;
        ctrl4_reg[p] <= 8'h01;
        ctrl8_reg[p] <= 8'h0F;
        ctrl9_reg[p] <= 8'h00;
        wt_reg[4*p+3] <= `QOSPT_RST_WT3; // R4
        wt_reg[4*p+2] <= `QOSPT_RST_WT2;
        wt_reg[4*p+1] <= `QOSPT_RST_WT1;
        wt_reg[4*p] <= `QOSPT_RST_WT0;
      end
      for (int d = 0; d < 16; d++) begin
        dscp_reg[d] <= 8'h00;
      end
      pri_map_reg <= {`QOSPT_RST_MAP_HI, `QOSPT_RST_MAP_LO};
      lvlmap_reg <= 8'h00;
    end else if (wr_en) begin
      for (int p = 0; p < 4; p++) begin
        if (idx == 8'(`QOSPT_PORT_STRIDE * (p + 1) + `QOSPT_OFF_CTRL0)) begin
          ctrl0_reg[p] <= pwdata[7:0];
        end
        if (idx == 8'(`QOSPT_PORT_STRIDE * (p + 1) + `QOSPT_OFF_CTRL2)) begin
          ctrl2_reg[p] <= pwdata[7:0];
        end
        if (idx == 8'(`QOSPT_PORT_STRIDE * (p + 1) + `QOSPT_OFF_CTRL3)) begin
          ctrl3_reg[p] <= pwdata[7:0]; // R15
        end
        if (idx == 8'(`QOSPT_PORT_STRIDE * (p + 1) + `QOSPT_OFF_CTRL4)) begin
          ctrl4_reg[p] <= pwdata[7:0]; // R15
        end
        if (idx == 8'(`QOSPT_PORT_STRIDE * (p + 1) + `QOSPT_OFF_CTRL8)) begin
          ctrl8_reg[p] <= pwdata[7:0];
        end
        if (idx == 8'(`QOSPT_PORT_STRIDE * (p + 1) + `QOSPT_OFF_CTRL9)) begin
          ctrl9_reg[p] <= pwdata[7:0];
        end
      end
      for (int d = 0; d < 16; d++) begin
        if (idx == 8'(`QOSPT_IDX_DSCP0 + d)) begin
          dscp_reg[d] <= pwdata[7:0]; // R18
        end
        if (idx == 8'(`QOSPT_IDX_WT0 + d)) begin
          wt_reg[d] <= pwdata[6:0]; // R4
        end
      end
      if (idx == `QOSPT_IDX_MAP_LO) begin
        pri_map_reg[7:0] <= pwdata[7:0];
      end
      if (idx == `QOSPT_IDX_MAP_HI) begin
        pri_map_reg[15:8] <= pwdata[7:0];
      end
      if (idx == `QOSPT_IDX_LVLMAP) begin
        lvlmap_reg <= pwdata[7:0];
      end
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit = 1'b0;
    for (int p = 0; p < 4; p++) begin
      if (idx == 8'(`QOSPT_PORT_STRIDE * (p + 1) + `QOSPT_OFF_CTRL0)) begin
        rd_data[7:0] = ctrl0_reg[p];
        rd_hit = 1'b1;
      end
      if (idx == 8'(`QOSPT_PORT_STRIDE * (p + 1) + `QOSPT_OFF_CTRL2)) begin
        rd_data[7:0] = ctrl2_reg[p];
        rd_hit = 1'b1;
      end
      if (idx == 8'(`QOSPT_PORT_STRIDE * (p + 1) + `QOSPT_OFF_CTRL3)) begin
        rd_data[7:0] = ctrl3_reg[p];
        rd_hit = 1'b1;
      end
      if (idx == 8'(`QOSPT_PORT_STRIDE * (p + 1) + `QOSPT_OFF_CTRL4)) begin
        rd_data[7:0] = ctrl4_reg[p];
        rd_hit = 1'b1;
      end
      if (idx == 8'(`QOSPT_PORT_STRIDE * (p + 1) + `QOSPT_OFF_CTRL8)) begin
        rd_data[7:0] = ctrl8_reg[p];
        rd_hit = 1'b1;
      end
      if (idx == 8'(`QOSPT_PORT_STRIDE * (p + 1) + `QOSPT_OFF_CTRL9)) begin
        rd_data[7:0] = ctrl9_reg[p];
        rd_hit = 1'b1;
      end
    end
    for (int d = 0; d < 16; d++) begin
      if (idx == 8'(`QOSPT_IDX_DSCP0 + d)) begin
        rd_data[7:0] = dscp_reg[d];
        rd_hit = 1'b1;
      end
      if (idx == 8'(`QOSPT_IDX_WT0 + d)) begin
        rd_data[6:0] = wt_reg[d];
        rd_hit = 1'b1;
      end
    end
    if (idx == `QOSPT_IDX_MAP_LO) begin
      rd_data[7:0] = pri_map_reg[7:0];
      rd_hit = 1'b1;
    end
    if (idx == `QOSPT_IDX_MAP_HI) begin
      rd_data[7:0] = pri_map_reg[15:8];
      rd_hit = 1'b1;
    end
    if (idx == `QOSPT_IDX_LVLMAP) begin
      rd_data[7:0] = lvlmap_reg;
      rd_hit = 1'b1;
    end
    if (idx == `QOSPT_IDX_STATUS) begin
      rd_data[19:0] = {fifo_level, frame_cnt_reg};
      rd_hit = 1'b1;
    end
    if (paddr[31:10] != 22'h000000 || paddr[1:0] != 2'b00) begin
      rd_hit = 1'b0;
      rd_data = 32'h0000_0000;
    end
  end

  // One access phase cycle: answer captured at the setup edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      // Error stands only beside its ready pulse
      pslverr <= setup && !rd_hit;
      if (setup) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_data;
      end
    end
  end

  // Classification of the frame at the ingress port
  logic [7:0] c0_in;
  logic [7:0] c0_eg;
  logic [1:0] lvl;
  logic [2:0] dflt_pri;
  logic [2:0] pcp_out;
  qospt_split_t split;
  qospt_desc_t desc_in;
  qospt_desc_t desc_out;
  logic desc_valid;
  logic desc_take;
  logic [3:0] fifo_lvl_raw;

  assign c0_in = ctrl0_reg[in_ingress];
  assign c0_eg = ctrl0_reg[in_egress];
  assign dflt_pri = ctrl3_reg[in_ingress][7:5];
  assign split = qospt_split_t'({ctrl9_reg[in_egress][`QOSPT_C9_SPLIT],
                                 c0_eg[`QOSPT_C0_SPLIT]}); // R1

  always_comb begin
    lvl = c0_in[`QOSPT_C0_PORTLVL +: 2]; // R6
    if (c0_in[`QOSPT_C0_DSCP] && in_is_ip) begin
      lvl = dscp_reg[in_dscp[5:2]][{in_dscp[1:0], 1'b0} +: 2]; // R17 R18
    end else if (c0_in[`QOSPT_C0_PRI8021P] && in_tagged) begin // R9
      lvl = pri_map_reg[{in_tci[15:13], 1'b0} +: 2]; // R8
    end
  end

  always_comb begin
    pcp_out = in_tci[15:13];
    if (ctrl2_reg[in_ingress][`QOSPT_C2_CEILING] && in_tci[15:13] > dflt_pri) begin
      pcp_out = dflt_pri; // R16
    end
  end

  always_comb begin
    desc_in.egress = in_egress;
    desc_in.level = lvl;
    unique case (split)
      QOSPT_SPLIT_ONE: desc_in.queue = 2'd0; // R3
      QOSPT_SPLIT_TWO: desc_in.queue = (lvl >= 2'(2'd3 - two_queue_level_map))
                                       ? 2'd1 : 2'd0; // R5 R7
      QOSPT_SPLIT_FOUR: desc_in.queue = lvl; // R2
      QOSPT_SPLIT_RSVD: desc_in.queue = 2'd0;
    endcase
    desc_in.ins = c0_eg[`QOSPT_C0_INSERT] && !in_tagged
                  && ctrl8_reg[in_egress][in_ingress]; // R10 R11
    desc_in.rem = c0_eg[`QOSPT_C0_REMOVE] && in_tagged; // R12
    if (desc_in.ins) begin
      desc_in.tci = {ctrl3_reg[in_ingress], ctrl4_reg[in_ingress]}; // R10 R15
    end else begin
      desc_in.tci = {pcp_out, in_tci[12:0]}; // R16
    end
  end

  qospt_fifo #(
    .WIDTH($bits(qospt_desc_t)),
    .DEPTH(`QOSPT_FIFO_DEPTH)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data(desc_in),
    .out_valid(desc_valid),
    .out_ready(desc_take),
    .out_data(desc_out),
    .level(fifo_lvl_raw)
  );
  assign fifo_level = fifo_lvl_raw;
  assign desc_take = !out_valid || out_ready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_cnt_reg <= 16'h0000;
    end else if (in_valid && in_ready) begin
      frame_cnt_reg <= 16'(frame_cnt_reg + 1'b1);
    end
  end

  // Output stage keeps every egress field on a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid <= 1'b0;
      out_egress <= 2'd0;
      out_queue <= 2'd0;
      out_level <= 2'd0;
      out_tag_insert <= 1'b0;
      out_tag_remove <= 1'b0;
      out_crc_recalc <= 1'b0;
      out_tci <= 16'h0000;
      out_vlan_protocol_identifier <= `QOSPT_VLAN_PROTOCOL_IDENTIFIER; // R13
    end else if (desc_take) begin
      out_valid <= desc_valid;
      if (desc_valid) begin
        out_egress <= desc_out.egress;
        out_queue <= desc_out.queue;
        out_level <= desc_out.level;
        out_tag_insert <= desc_out.ins;
        out_tag_remove <= desc_out.rem;
        out_crc_recalc <= desc_out.ins || desc_out.rem; // R14
        out_tci <= desc_out.tci; // R13
      end
    end
  end

  // Per-port transmit scheduler over the pending queues
  for (genvar gp = 0; gp < 4; gp++) begin : g_sched
    logic [6:0] credit_reg [4];
    logic [3:0] elig;
    logic [3:0] credited;
    logic [1:0] pick;
    logic found;
    logic reload;
    logic [1:0] sp_mode;

    assign sp_mode = {ctrl9_reg[gp][`QOSPT_C9_SPLIT], ctrl0_reg[gp][`QOSPT_C0_SPLIT]};

    always_comb begin
      unique case (sp_mode)
        2'b01: elig = q_pending[4*gp +: 4] & 4'h3;
        2'b10: elig = q_pending[4*gp +: 4];
        default: elig = q_pending[4*gp +: 4] & 4'h1; // R3
      endcase
      for (int q = 0; q < 4; q++) begin
        credited[q] = elig[q] && credit_reg[q] != 7'h00;
      end
      // Weighted mode reloads all credits once no pending queue has any
      reload = ctrl9_reg[gp][`QOSPT_C9_WFQ] && sp_mode == 2'b10
               && credited == 4'h0; // R4
      pick = 2'd0;
      found = 1'b0;
      for (int q = 0; q < 4; q++) begin
        if ((ctrl9_reg[gp][`QOSPT_C9_WFQ] && sp_mode == 2'b10 && !reload)
            ? credited[q] : elig[q]) begin
          pick = 2'(q); // R2
          found = 1'b1;
        end
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        for (int q = 0; q < 4; q++) begin
          credit_reg[q] <= 7'h00;
        end
      end else if (tx_take[gp] && found) begin
        for (int q = 0; q < 4; q++) begin
          if (reload) begin
            credit_reg[q] <= (2'(q) == pick) ? 7'(wt_reg[4*gp+q] - 1'b1)
                                             : wt_reg[4*gp+q]; // R4
          end else if (2'(q) == pick && credit_reg[q] != 7'h00) begin
            credit_reg[q] <= 7'(credit_reg[q] - 1'b1);
          end
        end
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        grant_valid[gp] <= 1'b0;
        grant_queue[2*gp +: 2] <= 2'd0;
      end else begin
        grant_valid[gp] <= tx_take[gp] && found;
        if (tx_take[gp] && found) begin
          grant_queue[2*gp +: 2] <= pick;
        end
      end
    end
  end
endmodule : qospt_top

// File: qospt_top_chk.sv
// Purpose: Port-level checker for the QoS tagging block
// Assumes: Zero-wait APB, one clock domain
// Notes: Bound from the bench top file
`timescale 1ns/1ps
`include "qospt_defines.svh"
module qospt_top_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [1:0] out_queue,
  input wire logic [1:0] out_level,
  input wire logic out_tag_insert,
  input wire logic out_tag_remove,
  input wire logic out_crc_recalc,
  input wire logic [15:0] out_tci,
  input wire logic [15:0] out_vlan_protocol_identifier,
  input wire logic [15:0] q_pending,
  input wire logic [3:0] tx_take,
  input wire logic [3:0] grant_valid,
  input wire logic [7:0] grant_queue
);
  logic [3:0] pend0_reg;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Grant of port 0 is judged against last cycle's pending set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pend0_reg <= 4'h0;
    else pend0_reg <= q_pending[3:0];
  end
  property p_apb_answer; psel && !penable |=> pready; endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("setup not answered");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than a cycle");
  property p_err_ready; pslverr |-> pready; endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  property p_vlan_protocol_identifier; out_vlan_protocol_identifier == `QOSPT_VLAN_PROTOCOL_IDENTIFIER; endproperty
  a_vlan_protocol_identifier: assert property (p_vlan_protocol_identifier) else $error("protocol id wrong");
  property p_crc; out_valid |-> out_crc_recalc == (out_tag_insert || out_tag_remove); endproperty
  a_crc: assert property (p_crc) else $error("crc flag wrong");
  property p_one_edit; out_valid |-> !(out_tag_insert && out_tag_remove); endproperty
  a_one_edit: assert property (p_one_edit) else $error("insert and remove together");
  property p_hold;
    out_valid && !out_ready |=> out_valid && $stable({out_queue, out_level, out_tci});
  endproperty
  a_hold: assert property (p_hold) else $error("descriptor changed while stalled");
  property p_grant_cause; grant_valid != 4'h0 |-> (grant_valid & ~$past(tx_take)) == 4'h0;
  endproperty
  a_grant_cause: assert property (p_grant_cause) else $error("grant without take");
  property p_grant_pend; grant_valid[0] |-> pend0_reg[grant_queue[1:0]]; endproperty
  a_grant_pend: assert property (p_grant_pend) else $error("idle queue granted");
  c_full: cover property (in_valid && !in_ready);
  c_grant: cover property (grant_valid[0]);
  c_insert: cover property (out_valid && out_tag_insert);
  c_err: cover property (pslverr);
endmodule : qospt_top_chk

// File: qospt_egress_model.sv
// Purpose: Egress sink that accepts descriptors
// Assumes: mode 0 prompt, 1 stalled, 2 ready one cycle in four
// Notes: Counts every accepted descriptor
`timescale 1ns/1ps
module qospt_egress_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] mode,
  input wire logic out_valid,
  output logic out_ready,
  output logic [7:0] count
);
  logic [1:0] ph_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ph_reg <= 2'h0;
    else ph_reg <= ph_reg + 2'h1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) out_ready <= 1'b0;
    else out_ready <= (mode == 2'h0) || (mode == 2'h2 && ph_reg == 2'h0);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) count <= 8'h00;
    else if (out_valid && out_ready) count <= count + 8'h01;
  end
endmodule : qospt_egress_model

// File: test_qos_priority_tagging.sv
// Purpose: Self-checking bench for the QoS tagging block
// Assumes: Port 0 serves as ingress, and as egress for all frames but one sent to port 1
// Notes: Table rows first, then awkward cases
`timescale 1ns/1ps
module test_qos_priority_tagging;
  typedef struct packed {
    logic [7:0] c0;
    logic [7:0] c9;
    logic tg;
    logic [15:0] ti;
    logic [5:0] ds;
    logic [1:0] lv;
    logic [1:0] q;
    logic ins;
    logic rem;
  } qospt_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic in_valid, in_ready, in_tagged, in_is_ip, out_valid, out_ready;
  logic [1:0] in_ingress, in_egress, out_egress, out_queue, out_level, mode;
  logic out_tag_insert, out_tag_remove, out_crc_recalc;
  logic [15:0] in_tci, out_tci, out_vlan_protocol_identifier, q_pending;
  logic [5:0] in_dscp;
  logic [3:0] tx_take, grant_valid;
  logic [7:0] grant_queue, count;
  int miscompares, checked, cycles, n, c;
  logic [7:0] rix [8] = '{8'h80, 8'h81, 8'hA3, 8'hA2, 8'hA1, 8'hA0, 8'h14, 8'h18};
  logic [7:0] rex [8] = '{8'h50, 8'hFA, 8'h08, 8'h04, 8'h02, 8'h01, 8'h01, 8'h0F};
  qospt_row_t rows [12] = '{
    '{8'h18, 8'h00, 1'b0, 16'h0000, 6'h00, 2'h3, 2'h0, 1'b0, 1'b0},
    '{8'h19, 8'h00, 1'b0, 16'h0000, 6'h00, 2'h3, 2'h1, 1'b0, 1'b0},
    '{8'h11, 8'h00, 1'b0, 16'h0000, 6'h00, 2'h2, 2'h0, 1'b0, 1'b0},
    '{8'h10, 8'h02, 1'b0, 16'h0000, 6'h00, 2'h2, 2'h2, 1'b0, 1'b0},
    '{8'h20, 8'h02, 1'b1, 16'hE000, 6'h00, 2'h3, 2'h3, 1'b0, 1'b0},
    '{8'h00, 8'h02, 1'b1, 16'hE000, 6'h00, 2'h0, 2'h0, 1'b0, 1'b0},
    '{8'h24, 8'h00, 1'b0, 16'h0000, 6'h00, 2'h0, 2'h0, 1'b1, 1'b0},
    '{8'h24, 8'h00, 1'b1, 16'h6123, 6'h00, 2'h1, 2'h0, 1'b0, 1'b0},
    '{8'h02, 8'h00, 1'b1, 16'h6123, 6'h00, 2'h0, 2'h0, 1'b0, 1'b1},
    '{8'h02, 8'h00, 1'b0, 16'h0000, 6'h00, 2'h0, 2'h0, 1'b0, 1'b0},
    '{8'h40, 8'h02, 1'b0, 16'h0000, 6'h05, 2'h3, 2'h3, 1'b0, 1'b0},
    '{8'h40, 8'h02, 1'b0, 16'h0000, 6'h04, 2'h0, 2'h0, 1'b0, 1'b0}};
  qospt_top qospt_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .in_valid(in_valid), .in_ready(in_ready), .in_ingress(in_ingress),
    .in_egress(in_egress), .in_tagged(in_tagged), .in_tci(in_tci), .in_is_ip(in_is_ip),
    .in_dscp(in_dscp), .out_valid(out_valid), .out_ready(out_ready), .out_egress(out_egress),
    .out_queue(out_queue), .out_level(out_level), .out_tag_insert(out_tag_insert),
    .out_tag_remove(out_tag_remove), .out_crc_recalc(out_crc_recalc), .out_tci(out_tci),
    .out_vlan_protocol_identifier(out_vlan_protocol_identifier), .q_pending(q_pending), .tx_take(tx_take),
    .grant_valid(grant_valid), .grant_queue(grant_queue));
  qospt_egress_model qospt_egress_model_i (.pclk(pclk), .presetn(presetn), .mode(mode),
    .out_valid(out_valid), .out_ready(out_ready), .count(count));
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] ix, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {22'h000000, ix, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] ix, input logic [31:0] d);
    apb(1'b1, ix, d);
  endtask : wr
  task automatic rdc(input string nm, input logic [7:0] ix, input logic [31:0] exp);
    apb(1'b0, ix, 32'h0);
    chk(nm, rd, exp);
  endtask : rdc
  task automatic xfer(input qospt_row_t r, input logic [15:0] et);
    in_valid <= 1'b1;
    in_tagged <= r.tg;
    in_tci <= r.ti;
    in_is_ip <= r.c0[6];
    in_dscp <= r.ds;
    do @(posedge pclk); while (in_ready !== 1'b1);
    in_valid <= 1'b0;
    do @(posedge pclk); while (out_valid !== 1'b1 || out_ready !== 1'b1);
    chk("level", 32'(out_level), 32'(r.lv));
    chk("queue", 32'(out_queue), 32'(r.q));
    chk("insert", 32'(out_tag_insert), 32'(r.ins));
    chk("remove", 32'(out_tag_remove), 32'(r.rem));
    chk("crc", 32'(out_crc_recalc), 32'(r.ins | r.rem));
    chk("egress", 32'(out_egress), 32'(in_egress));
    if (r.ins || (r.tg && !r.rem)) chk("tci", 32'(out_tci), 32'(et));
  endtask : xfer
  task automatic take(input int p, input logic g, input logic [1:0] q);
    tx_take <= 4'h1 << p;
    @(posedge pclk);
    tx_take <= 4'h0;
    @(posedge pclk);
    chk("grant", 32'(grant_valid[p]), 32'(g));
    if (g) chk("grant_q", 32'(grant_queue[2*p +: 2]), 32'(q));
  endtask : take
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, in_valid, in_tagged, in_is_ip} = '0;
    {in_ingress, in_egress, in_tci, in_dscp, q_pending, tx_take, mode} = '0;
    repeat (6) @(posedge pclk);
    chk("rst_ready", 32'(in_ready), 32'h0);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    wr(8'h13, 32'h45);
    wr(8'h14, 32'h67);
    wr(8'h82, 32'h00);
    wr(8'h91, 32'h0C);
    for (int i = 0; i < 12; i++) begin
      wr(8'h10, 32'(rows[i].c0));
      wr(8'h19, 32'(rows[i].c9));
      xfer(rows[i], rows[i].ins ? 16'h4567 : rows[i].ti);
    end
    wr(8'h10, 32'h00);
    wr(8'h12, 32'h80);
    // Unsplit egress port 1, ceiling still from ingress port 0
    in_egress <= 2'h1;
    xfer(qospt_row_t'{8'h00, 8'h00, 1'b1, 16'hE001, 6'h00, 2'h0, 2'h0, 1'b0, 1'b0}, 16'h4001);
    in_egress <= 2'h0;
    // Own port dropped from the source mask
    wr(8'h18, 32'h0E);
    wr(8'h10, 32'h24);
    xfer(qospt_row_t'{8'h24, 8'h00, 1'b0, 16'h0000, 6'h00, 2'h0, 2'h0, 1'b0, 1'b0}, 16'h0);
    rdc("unmapped", 8'hFF, 32'h0);
    chk("slverr", 32'(err), 32'h1);
    // Stall the sink until the buffer refuses, then drain slowly
    n = count;
    c = 0;
    mode <= 2'h1;
    in_valid <= 1'b1;
    repeat (20) begin
      @(posedge pclk);
      if (in_ready === 1'b1) c++;
    end
    in_valid <= 1'b0;
    chk("full", 32'(in_ready), 32'h0);
    apb(1'b0, 8'hC0, 32'h0);
    chk("fifo_full", 32'(rd[19:16]), 32'h8);
    mode <= 2'h2;
    repeat (80) @(posedge pclk);
    apb(1'b0, 8'hC0, 32'h0);
    chk("fifo_empty", 32'(rd[19:16]), 32'h0);
    chk("frames", 32'(rd[15:0]), 14 + c);
    chk("drained", 32'(count), n + c);
    q_pending <= 16'h0085;
    wr(8'h19, 32'h02);
    take(0, 1'b1, 2'h2);
    take(1, 1'b0, 2'h0);
    // Second reset restores defaults and clears credits
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    for (int i = 0; i < 8; i++) rdc("reset_val", rix[i], 32'(rex[i]));
    q_pending <= 16'h0009;
    wr(8'h19, 32'h03);
    for (int i = 0; i < 9; i++) take(0, 1'b1, i < 8 ? 2'h3 : 2'h0);
    final_report();
  end
endmodule : test_qos_priority_tagging
bind qospt_top qospt_top_chk qospt_top_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .in_valid(in_valid),
  .in_ready(in_ready), .out_valid(out_valid), .out_ready(out_ready), .out_queue(out_queue),
  .out_level(out_level), .out_tag_insert(out_tag_insert), .out_tag_remove(out_tag_remove),
  .out_crc_recalc(out_crc_recalc), .out_tci(out_tci), .out_vlan_protocol_identifier(out_vlan_protocol_identifier),
  .q_pending(q_pending), .tx_take(tx_take), .grant_valid(grant_valid),
  .grant_queue(grant_queue));
